/* File: grsc_ctrl.sv */
// Serial control port and configuration registers of the receiver
`timescale 1ns/10ps
`include "grsc_map.svh"

// How it works
// R01 - Controller shifts a 20-bit frame, data MSB first, while select is low.
// R02 - Data output driven only when test bus mode field is 01.
// R03 - Samples come as 2-bit or 3-bit format chosen by the mode bit.
// R04 - Clock select 1 uses reference clock; 0 uses RF LO divided by 96.
// R05 - Sample clock and three sample bits go out, clocked by sample clock.
// R06 - Controller sets reference divider for a 200kHz comparison frequency.
// R07 - RF LO is comparison times 8064, IF LO times 168, both fixed.
// R08 - Out-of-lock high and low flags read at status bits 9 and 8.
// R09 - Controller should set VCO coarse tune to 110.
// R10 - Controller should set the double charge-pump current bit to 1.
// R11 - Reading status never disturbs sampling or processing.
// R12 - Controller writes configuration once at startup only; the bench also rewrites it while running.
// R13 - Filter cutoff set by a 4-bit code in 16 steps.
// R14 - Converter DC offset set by a 4-bit DAC code from configuration.
// R15 - Frame ends with 4 address bits: 0100, 0101, 0110 select registers.
// R16 - Format bit picks which sample pin carries sign and magnitude.
// R17 - Standby bit stops sampling, but only with reference clock selected.
// R18 - Register loads when select rises; incomplete frames change nothing.
module grsc_ctrl
   import grsc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic sdi_i,
   output logic sdo_o,
   output logic sdo_oe_o,
   input wire logic reference_clock_in_i,
   input wire logic rf_lo_tick_i,
   input wire grsc_adc_t adc_i,
   input wire logic lock_hi_i,
   input wire logic lock_lo_i,
   input wire logic cal_end_i,
   input wire logic [3:0] autotune_word_i,
   output logic sample_clock_out_o,
   output logic sample_bit_hi_o,
   output logic sample_bit_mid_o,
   output logic sample_bit_lo_o,
   output logic comp_tick_o,
   output logic fb_tick_o,
   output logic if_lo_o,
   output logic lpf_autotune_o,
   output logic [3:0] lpf_code_o,
   output logic standby_o,
   output logic [7:0] ref_div_o,
   output logic [3:0] offset_dac_o,
   output logic cp_double_o,
   output logic [2:0] vco_coarse_o,
   output logic [4:0] agc_gain_o,
   output logic reset_cmos_o,
   output logic vco_force_lo_o,
   output logic vco_force_hi_o,
   output logic [4:0] analog_test_o
);

   grsc_ctrl_t s;
   grsc_ctrl_t next_s;
   logic [15:0] status;
   logic sclk_rise;
   logic sclk_fall;

   // ---------------------------------------------------------
   // Status word, even parity over the word
   // ---------------------------------------------------------
   always_comb begin
      status = {6'h00, lock_hi_i, lock_lo_i, s.synthesizer_register.clk_sel, 1'b0,
                1'b0, cal_end_i, autotune_word_i}; // [R08]
      status[6] = ^status;
   end

   // ---------------------------------------------------------
   // Serial engine; SCLK is sampled, so it must stay well below clk_i
   // ---------------------------------------------------------
   always_comb begin
      next_s = s;
      next_s.sclk_q = sclk_i;
      sclk_rise = sclk_i & ~s.sclk_q;
      sclk_fall = ~sclk_i & s.sclk_q;
      case (s.st)
         GRSC_IDLE: begin
            if (!cs_n_i) begin
               next_s.st = GRSC_SHIFT;
               next_s.cnt = 5'h00;
               // Snapshot status so a read sees a coherent word
               next_s.sdo = status[15];
               next_s.rd_sh = {status[14:0], 1'b0};
            end
         end
         GRSC_SHIFT: begin
            if (cs_n_i) begin
               next_s.st = GRSC_LOAD; // [R18]
            end else begin
               if (sclk_rise) begin
                  next_s.sh = {s.sh[18:0], sdi_i}; // [R01]
                  if (s.cnt != `GRSC_FRAME_OVER) begin
                     next_s.cnt = s.cnt + 5'h01;
                  end
               end
               // Readback bits change on the falling edge
               if (sclk_fall) begin
                  next_s.sdo = s.rd_sh[15];
                  next_s.rd_sh = {s.rd_sh[14:0], 1'b0};
               end
            end
         end
         GRSC_LOAD: begin
            next_s.st = GRSC_IDLE;
            // Only an exact 20-bit frame reaches a register
            if (s.cnt == `GRSC_FRAME_BITS) begin // [R18]
               case (s.sh[3:0]) // [R15]
                  `GRSC_ADDR_SYNTHESIZER_REGISTER: begin
                     next_s.synthesizer_register = s.sh[19:4];
                  end
                  `GRSC_ADDR_CFG1: begin
                     next_s.cfg1 = s.sh[19:4];
                  end
                  `GRSC_ADDR_CFG2: begin
                     next_s.cfg2 = s.sh[19:4];
                  end
                  default: begin
                     // Status address is a read: nothing changes [R11]
                     next_s.cnt = s.cnt;
                  end
               endcase
            end
         end
         default: begin
            next_s.st = GRSC_IDLE;
         end
      endcase
      // Output enable only in readback test mode and inside a frame
      next_s.sdo_oe = (next_s.st == GRSC_SHIFT)
                      && (s.cfg1.test_mode == `GRSC_TEST_READBACK); // [R02]
      // Standby honoured only with the reference clock selected
      next_s.standby_eff = next_s.synthesizer_register.standby
                           & next_s.synthesizer_register.clk_sel; // [R17]
   end

   // ---------------------------------------------------------
   // State register
   // ---------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s.st <= GRSC_IDLE;
         s.sclk_q <= 1'b0;
         s.sh <= 20'h00000;
         s.cnt <= 5'h00;
         s.rd_sh <= 16'h0000;
         s.sdo <= 1'b0;
         s.sdo_oe <= 1'b0;
         s.standby_eff <= 1'b0;
         s.synthesizer_register <= `GRSC_SYNTHESIZER_REGISTER_RST;
         s.cfg1 <= `GRSC_CFG1_RST;
         s.cfg2 <= `GRSC_CFG2_RST;
      end else begin
         s <= next_s;
      end
   end

   // ---------------------------------------------------------
   // Sample path; only register writes reach it, status reads never do
   // ---------------------------------------------------------
   grsc_sampler u_sampler (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .reference_clock_in_i(reference_clock_in_i),
      .rf_lo_tick_i(rf_lo_tick_i),
      .ref_div_i(s.synthesizer_register.ref_div),
      .clk_sel_i(s.synthesizer_register.clk_sel),
      .standby_i(s.synthesizer_register.standby),
      .adc_mode_i(s.cfg1.adc_mode),
      .adc_i(adc_i),
      .sample_clock_out_o(sample_clock_out_o),
      .sample_bit_hi_o(sample_bit_hi_o),
      .sample_bit_mid_o(sample_bit_mid_o),
      .sample_bit_lo_o(sample_bit_lo_o),
      .comp_tick_o(comp_tick_o),
      .fb_tick_o(fb_tick_o),
      .if_lo_o(if_lo_o)
   ); // [R05] [R11]

   // ---------------------------------------------------------
   // Configuration outputs, straight from the registers
   // ---------------------------------------------------------
   assign sdo_o = s.sdo;
   assign sdo_oe_o = s.sdo_oe;
   assign lpf_autotune_o = s.synthesizer_register.lpf_autotune;
   assign lpf_code_o = s.synthesizer_register.lpf_code; // [R13]
   assign standby_o = s.standby_eff; // [R17]
   assign ref_div_o = s.synthesizer_register.ref_div;
   assign offset_dac_o = {s.cfg1.ofs_sign, s.cfg1.ofs_msb,
                          s.cfg1.ofs_mid, s.cfg1.ofs_lsb}; // [R14]
   assign cp_double_o = s.cfg1.cp_double;
   assign vco_coarse_o = s.cfg1.vco_coarse;
   assign agc_gain_o = s.cfg1.agc_gain;
   assign reset_cmos_o = s.cfg2.reset_cmos;
   assign vco_force_lo_o = s.cfg2.vco_force_lo;
   assign vco_force_hi_o = s.cfg2.vco_force_hi;
   assign analog_test_o = s.cfg2.analog_test;

   // ---------------------------------------------------------
   // Checks
   // ---------------------------------------------------------
   sequence s_frame_end(logic [3:0] a);
      (s.st == GRSC_LOAD) && (s.cnt == `GRSC_FRAME_BITS) && (s.sh[3:0] == a);
   endsequence

   property p_synthesizer_register_write;
      @(posedge clk_i) disable iff (!rst_n_i)
      s_frame_end(`GRSC_ADDR_SYNTHESIZER_REGISTER) |=> (s.synthesizer_register == $past(s.sh[19:4]));
   endproperty
   a_synthesizer_register_write: assert property (p_synthesizer_register_write) // [R15]
      else $error("synthesizer register not loaded");

   property p_cfg1_write;
      @(posedge clk_i) disable iff (!rst_n_i)
      s_frame_end(`GRSC_ADDR_CFG1) |=> (s.cfg1 == $past(s.sh[19:4]));
   endproperty
   a_cfg1_write: assert property (p_cfg1_write) // [R18]
      else $error("first configuration register not loaded");

   property p_short_frame;
      @(posedge clk_i) disable iff (!rst_n_i)
      ((s.st == GRSC_LOAD) && (s.cnt != `GRSC_FRAME_BITS))
      |=> $stable(s.synthesizer_register) && $stable(s.cfg1) && $stable(s.cfg2);
   endproperty
   a_short_frame: assert property (p_short_frame) // [R18]
      else $error("incomplete frame changed a register");

   property p_read_quiet;
      @(posedge clk_i) disable iff (!rst_n_i)
      s_frame_end(`GRSC_ADDR_STATUS)
      |=> $stable(s.synthesizer_register) && $stable(s.cfg1) && $stable(s.cfg2);
   endproperty
   a_read_quiet: assert property (p_read_quiet) // [R11]
      else $error("status read changed a register");

   property p_shift_in;
      @(posedge clk_i) disable iff (!rst_n_i)
      ((s.st == GRSC_SHIFT) && !cs_n_i && sclk_i && !s.sclk_q)
      |=> (s.sh[0] == $past(sdi_i)) && (s.sh[19:1] == $past(s.sh[18:0]));
   endproperty
   a_shift_in: assert property (p_shift_in) // [R01]
      else $error("frame bit not shifted in");

   property p_sdo_gate;
      @(posedge clk_i) disable iff (!rst_n_i)
      (s.cfg1.test_mode != `GRSC_TEST_READBACK) |=> !sdo_oe_o;
   endproperty
   a_sdo_gate: assert property (p_sdo_gate) // [R02]
      else $error("data output enabled outside readback mode");

   property p_lock_snap;
      @(posedge clk_i) disable iff (!rst_n_i)
      ((s.st == GRSC_IDLE) && !cs_n_i)
      |=> (s.rd_sh[10] == $past(lock_hi_i))
          && (s.rd_sh[9] == $past(lock_lo_i));
   endproperty
   a_lock_snap: assert property (p_lock_snap) // [R08]
      else $error("lock flags not in status snapshot");

endmodule

/* File: grsc_map.svh */
// Constants for the receiver serial control block
`ifndef GRSC_MAP_SVH
`define GRSC_MAP_SVH

// ------------------------------------------------------------
// Serial frame
// ------------------------------------------------------------
`define GRSC_FRAME_BITS 5'h14
`define GRSC_FRAME_OVER 5'h15
`define GRSC_ADDR_SYNTHESIZER_REGISTER 4'h4
`define GRSC_ADDR_CFG1 4'h5
`define GRSC_ADDR_CFG2 4'h6
`define GRSC_ADDR_STATUS 4'h7
`define GRSC_TEST_READBACK 2'h1

// ------------------------------------------------------------
// Reset values of the writable registers
// ------------------------------------------------------------
`define GRSC_SYNTHESIZER_REGISTER_RST 16'hD260
`define GRSC_CFG1_RST 16'h803F
`define GRSC_CFG2_RST 16'h0000

// ------------------------------------------------------------
// Local oscillator division (counts of RF LO ticks)
// ------------------------------------------------------------
// Sample clock is RF LO / 96: toggle every 48 ticks
`define GRSC_SMP_HALF 6'h2F
// IF LO is comp x 168 = RF LO / 48: toggle every 24 ticks
`define GRSC_IF_HALF 5'h17
// Feedback divider: RF LO = comp x 8064
`define GRSC_FB_LAST 13'h1F7F

`endif

/* File: grsc_pkg.sv */
// Types shared by the receiver serial control block
package grsc_pkg;

   // ---------------------------------------------------------
   // Register layouts
   // ---------------------------------------------------------
   typedef struct packed {
      logic rsvd;
      logic lpf_autotune;
      logic [3:0] lpf_code;
      logic clk_sel;
      logic standby;
      logic [7:0] ref_div;
   } grsc_synthesizer_register_t;

   typedef struct packed {
      logic adc_mode;
      logic ofs_lsb;
      logic ofs_mid;
      logic ofs_msb;
      logic ofs_sign;
      logic cp_double;
      logic [1:0] test_mode;
      logic [2:0] vco_coarse;
      logic [4:0] agc_gain;
   } grsc_cfg1_t;

   typedef struct packed {
      logic reset_cmos;
      logic vco_force_lo;
      logic vco_force_hi;
      logic [7:0] rsvd;
      logic [4:0] analog_test;
   } grsc_cfg2_t;

   // ---------------------------------------------------------
   // Converter sample and serial engine state
   // ---------------------------------------------------------
   typedef struct packed {
      logic sign;
      logic [1:0] mag;
   } grsc_adc_t;

   typedef enum logic [2:0] {
      GRSC_IDLE = 3'h1,
      GRSC_SHIFT = 3'h2,
      GRSC_LOAD = 3'h4
   } grsc_state_t;

   typedef struct packed {
      grsc_state_t st;
      logic sclk_q;
      logic [19:0] sh;
      logic [4:0] cnt;
      logic [15:0] rd_sh;
      logic sdo;
      logic sdo_oe;
      logic standby_eff;
      grsc_synthesizer_register_t synthesizer_register;
      grsc_cfg1_t cfg1;
      grsc_cfg2_t cfg2;
   } grsc_ctrl_t;

   typedef struct packed {
      logic ref_q;
      logic [7:0] ref_cnt;
      logic comp_tick;
      logic [5:0] smp_cnt;
      logic smp_div_clk;
      logic [4:0] if_cnt;
      logic if_lo;
      logic [12:0] fb_cnt;
      logic fb_tick;
      logic sclk;
      logic hi;
      logic mid;
      logic lo;
   } grsc_smp_t;

endpackage

/* File: grsc_sampler.sv */
// Clock dividers, sample clock select and sample pin formatting
`timescale 1ns/10ps
`include "grsc_map.svh"

module grsc_sampler
   import grsc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic reference_clock_in_i,
   input wire logic rf_lo_tick_i,
   input wire logic [7:0] ref_div_i,
   input wire logic clk_sel_i,
   input wire logic standby_i,
   input wire logic adc_mode_i,
   input wire grsc_adc_t adc_i,
   output logic sample_clock_out_o,
   output logic sample_bit_hi_o,
   output logic sample_bit_mid_o,
   output logic sample_bit_lo_o,
   output logic comp_tick_o,
   output logic fb_tick_o,
   output logic if_lo_o
);

   grsc_smp_t s;
   grsc_smp_t next_s;
   logic run;
   logic src;

   // ---------------------------------------------------------
   // Next state
   // ---------------------------------------------------------
   always_comb begin
      next_s = s;
      next_s.ref_q = reference_clock_in_i;
      next_s.comp_tick = 1'b0;
      next_s.fb_tick = 1'b0;
      // Reference divider; a ratio of zero gives no ticks
      if (reference_clock_in_i && !s.ref_q) begin
         if (ref_div_i != 8'h00 && s.ref_cnt >= ref_div_i - 8'h01) begin
            next_s.ref_cnt = 8'h00;
            next_s.comp_tick = 1'b1;
         end else begin
            next_s.ref_cnt = s.ref_cnt + 8'h01;
         end
      end
      // Fixed LO ratios, not programmable [R07]
      if (rf_lo_tick_i) begin
         if (s.smp_cnt == `GRSC_SMP_HALF) begin
            next_s.smp_cnt = 6'h00;
            next_s.smp_div_clk = ~s.smp_div_clk; // [R04]
         end else begin
            next_s.smp_cnt = s.smp_cnt + 6'h01;
         end
         if (s.if_cnt == `GRSC_IF_HALF) begin
            next_s.if_cnt = 5'h00;
            next_s.if_lo = ~s.if_lo; // [R07]
         end else begin
            next_s.if_cnt = s.if_cnt + 5'h01;
         end
         if (s.fb_cnt == `GRSC_FB_LAST) begin
            next_s.fb_cnt = 13'h0000;
            next_s.fb_tick = 1'b1; // [R07]
         end else begin
            next_s.fb_cnt = s.fb_cnt + 13'h0001;
         end
      end
      // Standby holds the sample clock low; honoured only on ref clock
      run = !(standby_i && clk_sel_i); // [R17]
      src = clk_sel_i ? reference_clock_in_i : s.smp_div_clk; // [R04]
      next_s.sclk = run & src; // [R05]
      // Capture on the rising edge of the sample clock itself
      if (next_s.sclk && !s.sclk) begin
         if (adc_mode_i) begin
            next_s.hi = adc_i.sign; // [R03] [R16]
            next_s.mid = adc_i.mag[1];
            next_s.lo = 1'b0;
         end else begin
            next_s.hi = adc_i.mag[1]; // [R03] [R16]
            next_s.mid = adc_i.mag[0];
            next_s.lo = adc_i.sign;
         end
      end
   end

   // ---------------------------------------------------------
   // State register
   // ---------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // Outputs straight from flops
   assign sample_clock_out_o = s.sclk;
   assign sample_bit_hi_o = s.hi;
   assign sample_bit_mid_o = s.mid;
   assign sample_bit_lo_o = s.lo;
   assign comp_tick_o = s.comp_tick;
   assign fb_tick_o = s.fb_tick;
   assign if_lo_o = s.if_lo;

   // ---------------------------------------------------------
   // Checks
   // ---------------------------------------------------------
   property p_ref_follow;
      @(posedge clk_i) disable iff (!rst_n_i)
      (clk_sel_i && !standby_i)
      |=> (sample_clock_out_o == $past(reference_clock_in_i));
   endproperty
   a_ref_follow: assert property (p_ref_follow) // [R04]
      else $error("sample clock does not follow reference");

   property p_standby;
      @(posedge clk_i) disable iff (!rst_n_i)
      (standby_i && clk_sel_i) |=> !sample_clock_out_o;
   endproperty
   a_standby: assert property (p_standby) // [R17]
      else $error("sample clock runs in standby");

   property p_fmt_two;
      @(posedge clk_i) disable iff (!rst_n_i)
      ($rose(sample_clock_out_o) && $past(adc_mode_i))
      |-> (sample_bit_hi_o == $past(adc_i.sign)) && !sample_bit_lo_o;
   endproperty
   a_fmt_two: assert property (p_fmt_two) // [R16]
      else $error("two bit format mapping wrong");

   property p_fmt_three;
      @(posedge clk_i) disable iff (!rst_n_i)
      ($rose(sample_clock_out_o) && !$past(adc_mode_i))
      |-> (sample_bit_lo_o == $past(adc_i.sign))
          && (sample_bit_hi_o == $past(adc_i.mag[1]));
   endproperty
   a_fmt_three: assert property (p_fmt_three) // [R03]
      else $error("three bit format mapping wrong");

endmodule

/* File: grsc_spi_host.sv */
// Serial controller model that drives the control port frames
`timescale 1ns/10ps

module grsc_spi_host (
   input wire logic clk_i,
   output logic sclk_o,
   output logic cs_n_o,
   output logic sdi_o,
   input wire logic sdo_i,
   input wire logic sdo_oe_i
);
   // Idle link: clock parked low, select high
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      sdi_o = 1'b0;
   end

   // Changes land just after an edge, never on it
   task automatic step(input int k);
      repeat (k) @(posedge clk_i);
      #10;
   endtask

   // ---------------------------------------------------------
   // One frame: n bits from the top of w, readback captured
   // ---------------------------------------------------------
   // Each clock level spans 2 cycles; the port sets no upper limit on it
   task automatic xfer(input logic [19:0] w, input int n,
      output logic [15:0] rd, output logic oe);
      rd = 16'h0000;
      oe = 1'b1;
      cs_n_o = 1'b0;
      step(2);
      for (int i = 0; i < n; i++) begin
         sdi_o = (i < 20) ? w[19 - i] : 1'b0;
         sclk_o = 1'b0;
         step(2);
         sclk_o = 1'b1;
         step(2);
         if (i < 16) begin
            rd[15 - i] = sdo_i;
            oe = oe & sdo_oe_i;
         end
      end
      sclk_o = 1'b0;
      step(2);
      cs_n_o = 1'b1;
      sdi_o = ~sdi_o;  // Released line shows no stale value
      step(5);
   endtask
endmodule

/* File: tb_top.sv */
// Self-checking bench for the receiver serial control block
`timescale 1ns/10ps
`include "grsc_map.svh"

module tb_top
   import grsc_pkg::*;
();
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic sclk_i, cs_n_i, sdi_i, sdo_o, sdo_oe_o;
   logic reference_clock_in_i = 1'b0;
   logic rf_lo_tick_i = 1'b0;
   grsc_adc_t adc_i = 3'h0;
   logic lock_hi_i = 1'b0;
   logic lock_lo_i = 1'b0;
   logic cal_end_i = 1'b0;
   logic [3:0] autotune_word_i = 4'h0;
   logic sample_clock_out_o, sample_bit_hi_o, sample_bit_mid_o;
   logic sample_bit_lo_o, comp_tick_o, fb_tick_o, if_lo_o;
   logic lpf_autotune_o, standby_o, cp_double_o, reset_cmos_o;
   logic vco_force_lo_o, vco_force_hi_o;
   logic [3:0] lpf_code_o, offset_dac_o;
   logic [7:0] ref_div_o;
   logic [2:0] vco_coarse_o;
   logic [4:0] agc_gain_o, analog_test_o;
   logic [15:0] mreg [4:6];
   logic [31:0] rnd = 32'h3758CC70;
   logic [31:0] bg = 32'h3758CC70;
   int miscompares = 0;
   int checks = 0;
   int cycles = 0;
   int refc = 0;
   int n;
   logic mon_on = 1'b0;
   logic lo_full = 1'b0;
   logic ref_prev, sco_prev, oe;
   logic [15:0] rd;
   grsc_adc_t adc_prev;
   wire sdo_line = sdo_oe_o ? sdo_o : 1'bz;
   wire [2:0] pins = {sample_bit_hi_o, sample_bit_mid_o, sample_bit_lo_o};
   wire [13:0] syn_seen = {lpf_autotune_o, lpf_code_o, standby_o, ref_div_o};
   wire [12:0] cf1_seen = {offset_dac_o, cp_double_o, vco_coarse_o,
      agc_gain_o};
   wire [7:0] cf2_seen = {reset_cmos_o, vco_force_lo_o, vco_force_hi_o,
      analog_test_o};

   grsc_ctrl grsc_ctrl_inst (.clk_i, .rst_n_i, .sclk_i, .cs_n_i, .sdi_i,
      .sdo_o, .sdo_oe_o, .reference_clock_in_i, .rf_lo_tick_i, .adc_i,
      .lock_hi_i, .lock_lo_i, .cal_end_i, .autotune_word_i,
      .sample_clock_out_o, .sample_bit_hi_o, .sample_bit_mid_o,
      .sample_bit_lo_o, .comp_tick_o, .fb_tick_o, .if_lo_o,
      .lpf_autotune_o, .lpf_code_o, .standby_o, .ref_div_o, .offset_dac_o,
      .cp_double_o, .vco_coarse_o, .agc_gain_o, .reset_cmos_o,
      .vco_force_lo_o, .vco_force_hi_o, .analog_test_o);
   grsc_spi_host grsc_spi_host_inst (.clk_i, .sclk_o(sclk_i),
      .cs_n_o(cs_n_i), .sdi_o(sdi_i), .sdo_i(sdo_line),
      .sdo_oe_i(sdo_oe_o));

   // ---------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [2:0] fmt(input grsc_adc_t a, input logic m);
      return m ? {a.sign, a.mag[1], 1'b0} : {a.mag, a.sign};
   endfunction
   function automatic logic [15:0] status_exp();
      logic [15:0] s;
      s = {6'h00, lock_hi_i, lock_lo_i, mreg[4][9], 2'h0, cal_end_i,
         autotune_word_i};
      s[6] = ^s;  // Even parity over the whole word
      return s;
   endfunction
   function automatic logic pick(input int sel);
      case (sel)
         0: return sample_clock_out_o;
         1: return if_lo_o;
         2: return fb_tick_o;
         default: return comp_tick_o;
      endcase
   endfunction
   task automatic check(input string name, input logic [31:0] seen,
      input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic conclude();
      if (miscompares == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic step(input int k);
      repeat (k) @(posedge clk_i);
      #10;
   endtask
   task automatic check_regs();
      logic [15:0] s, c, g;
      logic [31:0] e;
      s = mreg[4];
      c = mreg[5];
      g = mreg[6];
      e = {s[14], s[13:10], s[9] & s[8], s[7:0]};
      check("synthesizer_register", syn_seen, e);
      e = {c[11], c[12], c[13], c[14], c[10], c[7:5], c[4:0]};
      check("cfg1", cf1_seen, e);
      e = {g[15:13], g[4:0]};
      check("cfg2", cf2_seen, e);
   endtask
   // Monitor paused while a write may move the clock source
   task automatic wr(input logic [3:0] a, input logic [15:0] d, input int k);
      logic keep;
      keep = mon_on;
      mon_on = 1'b0;
      grsc_spi_host_inst.xfer({d, a}, k, rd, oe);
      if (k == 20 && a >= 4'h4 && a <= 4'h6) begin
         mreg[a] = d;
      end
      step(3);
      check_regs();
      mon_on = keep;
   endtask
   task automatic rd_status(input logic en);
      logic [15:0] e;
      rnd = lfsr(rnd);
      {lock_hi_i, lock_lo_i, cal_end_i, autotune_word_i} = rnd[6:0];
      step(1);
      e = status_exp();
      grsc_spi_host_inst.xfer({16'h0000, `GRSC_ADDR_STATUS}, 20, rd, oe);
      check("sdo_enable", oe, en);
      if (en) begin
         check("status", rd, e);
      end
   endtask
   task automatic lvl(input int sel, input logic v, inout int t);
      do begin
         @(negedge clk_i);
         t++;
      end while (pick(sel) !== v && t < 20000);
   endtask
   // Cycles from one rise of the chosen output to the next
   task automatic gap(input int sel, input int exp);
      int t;
      t = 0;
      lvl(sel, 1'b0, t);
      lvl(sel, 1'b1, t);
      t = 0;
      lvl(sel, 1'b0, t);
      lvl(sel, 1'b1, t);
      check("period", 32'(t), 32'(exp));
      step(1);
   endtask

   // ---------------------------------------------------------
   // Clock, background stimulus, monitor, timeout
   // ---------------------------------------------------------
   initial begin
      forever #50 clk_i = ~clk_i;
   end
   // Reference toggles every 3 cycles, well under half the clock
   always @(posedge clk_i) begin
      #10;
      bg = lfsr(bg);
      adc_i = bg[2:0];
      rf_lo_tick_i = lo_full | bg[3];
      refc = (refc == 2) ? 0 : refc + 1;
      if (refc == 0) begin
         reference_clock_in_i = ~reference_clock_in_i;
      end
   end
   // Sampled at the falling edge, where flop outputs have settled
   always @(negedge clk_i) begin
      if (mon_on && mreg[4][9] && !mreg[4][8]) begin
         check("follow", sample_clock_out_o, ref_prev);
      end
      if (mon_on && sample_clock_out_o && !sco_prev) begin
         check("pins", pins, fmt(adc_prev, mreg[5][15]));
      end
      ref_prev = reference_clock_in_i;
      adc_prev = adc_i;
      sco_prev = sample_clock_out_o;
   end
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 40000) begin
         miscompares++;
         conclude();
      end
   end

   // ---------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------
   initial begin
      mreg[4] = `GRSC_SYNTHESIZER_REGISTER_RST;
      mreg[5] = `GRSC_CFG1_RST;
      mreg[6] = `GRSC_CFG2_RST;
      repeat (12) @(posedge clk_i);
      #10;
      rst_n_i = 1'b1;
      step(1);
      check_regs();
      rd_status(1'b0);
      for (int i = 0; i < 18; i++) begin
         rnd = lfsr(rnd);
         wr(4'h4 + 4'(i % 3), rnd[15:0], 20);
      end
      rnd = lfsr(rnd);
      wr(4'h5, rnd[15:0], 19);
      wr(4'h6, rnd[31:16], 21);
      wr(4'h7, rnd[15:0], 20);
      wr(4'h3, rnd[31:16], 20);
      wr(4'h4, 16'h0205, 20);
      wr(4'h5, 16'h85DF, 20);
      mon_on = 1'b1;
      repeat (3) rd_status(1'b1);
      gap(3, 30);
      wr(4'h5, 16'h05DF, 20);
      repeat (2) rd_status(1'b1);
      wr(4'h4, 16'h0305, 20);
      n = 0;
      repeat (40) begin
         @(negedge clk_i);
         n += int'(sample_clock_out_o);
      end
      check("standby_clk", 32'(n), 32'h0);
      step(1);
      lo_full = 1'b1;
      wr(4'h4, 16'h0005, 20);
      gap(0, 96);
      gap(1, 48);
      gap(2, 8064);
      wr(4'h4, 16'h0105, 20);
      gap(0, 96);
      conclude();
   end
endmodule
